// ### logic/sbr_pkg.sv
// Package: command encodings, burst and refresh timing for the DRAM core
// Operation
// - Select bit picks chop-four or full-eight burst
// - Select bit never enters the column address
// - Burst choice works with or without auto-precharge
// - Data setup/hold fault corrupts only that location
// - Strobe timing fault corrupts only, never hangs
// - Refresh decoded from select, row, column, write
// - Refresh rows come from internal counter
// - Refresh completion leaves all banks idle
package sbr_pkg;
   localparam int unsigned CLK_MHZ            = 125;
   localparam int unsigned COL_TO_COL_DELAY   = 4;
   localparam int unsigned CHOP_BEATS         = 4;
   localparam int unsigned FULL_BEATS         = 8;
   localparam int unsigned BURST_SEL_POS      = 12;
   localparam int unsigned AUTO_PRE_POS       = 10;
   localparam int unsigned REFRESH_CYCLE_NS   = 110;
   localparam int unsigned REFRESH_CYCLE_CYC  =
      (REFRESH_CYCLE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned AVG_REFRESH_NS     = 7800;
   localparam int unsigned AVG_REFRESH_CYC    =
      (AVG_REFRESH_NS * CLK_MHZ) / 1000;
   localparam int unsigned MAX_POSTPONE       = 8;
   localparam int unsigned MAX_PULL_IN        = 8;
   localparam logic [15:0] ROW_CNT_RESET      = 16'h0000;
   // Command bus bits: {cs_b, ras_b, cas_b, we_b}
   localparam logic [3:0]  CMD_REFRESH        = 4'h1;
   localparam logic [3:0]  CMD_READ           = 4'h5;
   localparam logic [3:0]  CMD_WRITE          = 4'h4;
   localparam logic [3:0]  CMD_NOP            = 4'h7;
   typedef enum logic [1:0] {SBR_IDLE, SBR_REFRESH} sbr_state_t;
endpackage

// ### logic/sbr_row_counter.sv
// Internal refresh row address counter
`timescale 1ns/1ps
module sbr_row_counter
   import sbr_pkg::*;
#(
   parameter int unsigned ROW_W = 13
)
(
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             rst_b,
   // Control
   input  wire logic             step,
   // Row address
   output logic [ROW_W-1:0]      row_q
);
   initial
   begin
      if (ROW_W < 1 || ROW_W > 16)
         $error("sbr_row_counter: ROW_W out of range");
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         row_q <= ROW_CNT_RESET[ROW_W-1:0];
      else if (step)
         row_q <= row_q + {{(ROW_W-1){1'b0}}, 1'b1};
   end
endmodule

// ### logic/sbr_dram_core.sv
// Command decoder: per-command burst length and refresh sequencing
`timescale 1ns/1ps
module sbr_dram_core
   import sbr_pkg::*;
#(
   parameter int unsigned ROW_W      = 13,
   parameter int unsigned COL_W      = 10,
   parameter int unsigned REFI_CYC   = AVG_REFRESH_CYC
)
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   // Command pins from controller
   input  wire logic              cs_b,
   input  wire logic              ras_b,
   input  wire logic              cas_b,
   input  wire logic              we_b,
   input  wire logic [15:0]       addr,
   // Column access
   output logic                   col_valid_q,
   output logic                   col_write_q,
   output logic                   col_auto_pre_q,
   output logic [COL_W-1:0]       col_addr_q,
   output logic [3:0]             burst_beats_q,
   output logic                   burst_chop_of_four_q,
   // Refresh
   output logic                   refresh_busy_q,
   output logic                   banks_idle_q,
   output logic [ROW_W-1:0]       refresh_row_q,
   output logic [4:0]             refresh_credit_q,
   output logic                   refresh_overdue_q
);
   // Burst select and auto-precharge must sit above the column field
   initial
   begin
      if (COL_W < 1 || COL_W > BURST_SEL_POS - 2)
         $error("sbr_dram_core: COL_W out of range");
      if (ROW_W < 1 || ROW_W > 16)
         $error("sbr_dram_core: ROW_W out of range");
      if (REFI_CYC < 2)
         $error("sbr_dram_core: REFI_CYC too small");
   end

   localparam int unsigned RFC_W = $clog2(REFRESH_CYCLE_CYC + 1);
   localparam int unsigned RI_W  = $clog2(REFI_CYC + 1);

   sbr_state_t              state_q;
   logic [RFC_W-1:0]        rfc_cnt_q;
   logic [RI_W-1:0]         refi_cnt_q;
   logic                    row_step;
   logic [3:0]              cmd;
   logic                    is_ref;
   logic                    is_col;
   logic                    col_take;
   logic                    tick;
   logic                    held;

   // One decoder serves the refresh and the column paths alike
   function automatic logic cmd_is(input logic [3:0] pins,
                                   input logic [3:0] code);
      cmd_is = (pins == code);
   endfunction

   // The array stays held from the refresh edge until the counter
   // runs out; busy and idle both come from this one term so that
   // they can never disagree for a cycle
   function automatic logic array_held(input sbr_state_t       s,
                                       input logic [RFC_W-1:0] n,
                                       input logic             r);
      array_held = r || (s == SBR_REFRESH && n != '0);
   endfunction

   // Pins are sampled on the same clock edge as the controller drives,
   // so no synchroniser stands in front of them
   assign cmd      = {cs_b, ras_b, cas_b, we_b};
   assign is_ref   = cmd_is(cmd, CMD_REFRESH) &&
                     (state_q == SBR_IDLE);
   assign is_col   = cmd_is(cmd, CMD_READ) || cmd_is(cmd, CMD_WRITE);
   // Column commands are ignored while refresh owns the array
   assign col_take = is_col && (state_q == SBR_IDLE);
   // The row counter steps on the refresh edge itself
   assign row_step = is_ref;
   assign held     = array_held(state_q, rfc_cnt_q, is_ref);
   // Average interval tick; the credit logic compares against it
   assign tick     = (refi_cnt_q == RI_W'(REFI_CYC - 1));

   // Column bits skip auto-precharge and burst select positions
   function automatic logic [COL_W-1:0] col_of(input logic [15:0] a);
      logic [15:0] packed_col;
      packed_col = {a[15:BURST_SEL_POS+1], a[BURST_SEL_POS-1:AUTO_PRE_POS+1],
                    a[AUTO_PRE_POS-1:0], 2'b00};
      col_of = packed_col[COL_W+1:2];
   endfunction

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         col_valid_q          <= 1'b0;
         col_write_q          <= 1'b0;
         col_auto_pre_q       <= 1'b0;
         col_addr_q           <= '0;
         burst_beats_q        <= 4'h8;
         burst_chop_of_four_q <= 1'b0;
      end
      else
      begin
         col_valid_q <= col_take;
         if (col_take)
         begin
            // A write with broken strobe timing still lands only at
            // this column; nothing here waits on the strobes, so a
            // bad burst cannot stall the decoder
            col_write_q    <= ~we_b;
            col_auto_pre_q <= addr[AUTO_PRE_POS];
            col_addr_q     <= col_of(addr);
            burst_chop_of_four_q <= ~addr[BURST_SEL_POS];
            burst_beats_q  <= addr[BURST_SEL_POS] ?
                              FULL_BEATS[3:0] : CHOP_BEATS[3:0];
         end
      end
   end

   // Refresh sequencer; address pins are never looked at here
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         state_q   <= SBR_IDLE;
         rfc_cnt_q <= '0;
      end
      else
      begin
         case (state_q)
            SBR_IDLE:
            begin
               // A refresh seen while busy never reaches this branch,
               // so it is dropped without disturbing the running one
               if (is_ref)
               begin
                  state_q   <= SBR_REFRESH;
                  // Load edge counts as the first busy cycle
                  rfc_cnt_q <= RFC_W'(REFRESH_CYCLE_CYC - 1);
               end
            end
            SBR_REFRESH:
            begin
               if (rfc_cnt_q == '0)
                  state_q <= SBR_IDLE;
               else
                  rfc_cnt_q <= rfc_cnt_q - RFC_W'(1);
            end
            // An illegal state falls back to idle rather than hanging
            default:
               state_q <= SBR_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         refresh_busy_q <= 1'b0;
         banks_idle_q   <= 1'b1;
      end
      else
      begin
         refresh_busy_q <= held;
         banks_idle_q   <= !held;
      end
   end

   // Credit: 8 means on schedule; below is postponed, above pulled in.
   // Saturation keeps extra pulled-in refreshes from earning credit.
   // A tick that meets a refresh cancels out, so no refresh is lost
   // or counted twice in that cycle.
   // Overdue stays set until a refresh lands at zero credit with no tick; its set
   // and clear conditions exclude each other.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         refi_cnt_q        <= '0;
         refresh_credit_q  <= 5'(MAX_POSTPONE);
         refresh_overdue_q <= 1'b0;
      end
      else
      begin
         refi_cnt_q <= tick ? '0 : refi_cnt_q + RI_W'(1);
         if (tick && !is_ref)
         begin
            if (refresh_credit_q != 5'h00)
               refresh_credit_q <= refresh_credit_q - 5'h01;
            else
               refresh_overdue_q <= 1'b1;
         end
         else if (is_ref && !tick)
         begin
            if (refresh_credit_q != 5'(MAX_POSTPONE + MAX_PULL_IN))
               refresh_credit_q <= refresh_credit_q + 5'h01;
         end
         if (is_ref && refresh_credit_q == 5'h00 && !tick)
            refresh_overdue_q <= 1'b0;
      end
   end

   sbr_row_counter #(
      .ROW_W (ROW_W)
   ) u_row (
      .sys_clk (sys_clk),
      .rst_b   (rst_b),
      .step    (row_step),
      .row_q   (refresh_row_q)
   );
endmodule

// ### tb/sbr_dram_core_monitor.sv
// Port-level assertions for the DRAM command core
`timescale 1ns/1ps
module sbr_dram_core_monitor
   import sbr_pkg::*;
#(
   parameter int unsigned ROW_W = 13,
   parameter int unsigned COL_W = 10
)
(
   input wire logic             sys_clk,
   input wire logic             rst_b,
   input wire logic             cs_b,
   input wire logic             ras_b,
   input wire logic             cas_b,
   input wire logic             we_b,
   input wire logic [15:0]      addr,
   input wire logic             col_valid_q,
   input wire logic             col_write_q,
   input wire logic             col_auto_pre_q,
   input wire logic [COL_W-1:0] col_addr_q,
   input wire logic [3:0]       burst_beats_q,
   input wire logic             burst_chop_of_four_q,
   input wire logic             refresh_busy_q,
   input wire logic             banks_idle_q,
   input wire logic [ROW_W-1:0] refresh_row_q,
   input wire logic [4:0]       refresh_credit_q
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   wire logic col_go = {cs_b, ras_b, cas_b} == 3'h2 && !refresh_busy_q;
   wire logic ref_go = {cs_b, ras_b, cas_b, we_b} == CMD_REFRESH &&
      !refresh_busy_q;
   sequence ref_run;
      refresh_busy_q [*8] ##1 refresh_busy_q [*6] ##1 banks_idle_q;
   endsequence
   col_accept_a: assert property (col_go |=> col_valid_q)
      else $error("column command not accepted");
   col_cause_a: assert property (col_valid_q |-> $past(col_go))
      else $error("column pulse without command");
   burst_len_a: assert property (col_go |=>
      burst_beats_q == ($past(addr[12]) ? 4'h8 : 4'h4) &&
      burst_chop_of_four_q == !$past(addr[12]))
      else $error("wrong burst length");
   col_field_a: assert property (col_go |=>
      col_addr_q == $past(addr[COL_W-1:0]) && col_auto_pre_q == $past(addr[10])
      && col_write_q == !$past(we_b)) else $error("wrong column fields");
   ref_span_a: assert property (ref_go |=> ref_run)
      else $error("refresh span wrong");
   ref_row_a: assert property (ref_go |=>
      refresh_row_q == $past(refresh_row_q) + 1'b1) else $error("row step");
   ref_credit_a: assert property (ref_go |=>
      refresh_credit_q - $past(refresh_credit_q) <= 5'h01 ||
      $past(refresh_credit_q) == 5'h10) else $error("credit step wrong");
   credit_cap_a: assert property (refresh_credit_q <= 5'h10)
      else $error("credit above limit");
endmodule
bind sbr_dram_core sbr_dram_core_monitor #(.ROW_W(ROW_W), .COL_W(COL_W))
   u_sbr_dram_core_monitor (.sys_clk(sys_clk), .rst_b(rst_b), .cs_b(cs_b),
   .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .addr(addr),
   .col_valid_q(col_valid_q), .col_write_q(col_write_q),
   .col_auto_pre_q(col_auto_pre_q), .col_addr_q(col_addr_q),
   .burst_beats_q(burst_beats_q), .burst_chop_of_four_q(burst_chop_of_four_q),
   .refresh_busy_q(refresh_busy_q), .banks_idle_q(banks_idle_q),
   .refresh_row_q(refresh_row_q), .refresh_credit_q(refresh_credit_q));

// ### tb/sbr_ctrl_model.sv
// Memory controller partner driving the command pins
`timescale 1ns/1ps
module sbr_ctrl_model
   import sbr_pkg::*;
(
   // Clock and status
   input  wire logic        sys_clk,
   input  wire logic        banks_idle_q,
   // Command pins
   output logic [3:0]       cmd_pins,
   output logic [15:0]      addr
);
   initial
   begin
      cmd_pins = CMD_NOP;
      addr = 16'h0000;
   end
   // Refresh waits out the busy span; reads and writes go at once
   task automatic issue(input logic [3:0] cmd, input logic [15:0] a);
      #1;
      while (cmd == CMD_REFRESH &&
             banks_idle_q !== 1'b1)
      begin
         cmd_pins = CMD_NOP;
         addr = ~addr;
         @(posedge sys_clk);
         #1;
      end
      cmd_pins = cmd;
      addr = a;
      @(posedge sys_clk);
   endtask
endmodule

// ### tb/test_sbr_dram_core.sv
// Self-checking bench for the DRAM command core
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin mismatches++; \
   $display("BAD %0t %h %h", $time, a, e); end end
module test_sbr_dram_core;
   import sbr_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic [3:0]  pins;
   logic [15:0] addr, a;
   logic        cv, cw, cap, chop, busy, idle, ovd, busy_was;
   logic [9:0]  col;
   logic [3:0]  beats;
   logic [12:0] row, row_e;
   logic [4:0]  cred, cred_e;
   logic [31:0] expq[$];
   integer      seed = 32'h4932ce85;
   int          mismatches = 0;
   int          checks = 0;
   always #4 sys_clk = ~sys_clk;
   sbr_ctrl_model u_sbr_ctrl_model (.sys_clk(sys_clk), .banks_idle_q(idle),
      .cmd_pins(pins), .addr(addr));
   sbr_dram_core #(.REFI_CYC(4000)) u_sbr_dram_core (.sys_clk(sys_clk),
      .rst_b(rst_b), .cs_b(pins[3]), .ras_b(pins[2]), .cas_b(pins[1]),
      .we_b(pins[0]), .addr(addr), .col_valid_q(cv), .col_write_q(cw),
      .col_auto_pre_q(cap), .col_addr_q(col), .burst_beats_q(beats),
      .burst_chop_of_four_q(chop), .refresh_busy_q(busy),
      .banks_idle_q(idle), .refresh_row_q(row), .refresh_credit_q(cred),
      .refresh_overdue_q(ovd));
   function automatic logic [31:0] pop();
      if (expq.size() == 0)
         return 'x;
      return expq.pop_front();
   endfunction
   task automatic tally_and_finish();
      if (mismatches == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Unexpected answers pop an unknown and so always mismatch
   always @(negedge sys_clk)
   begin
      busy_was <= busy;
      if (rst_b && cv === 1'b1)
         `CHK({15'h0, beats, chop, cw, cap, col},
            pop())
      if (rst_b && busy === 1'b1 && busy_was !== 1'b1)
         `CHK({14'h0, row, cred},
            pop())
   end
   initial
   begin
      #600000;
      mismatches++;
      tally_and_finish();
   end
   initial
   begin
      repeat (12) @(posedge sys_clk);
      #1 rst_b = 1'b1;
      row_e = 13'h0000;
      cred_e = 5'h08;
      for (int i = 0; i < 40; i++)
      begin
         a = 16'($random(seed));
         expq.push_back({15'h0, a[12] ? 4'h8 : 4'h4, ~a[12], a[15], a[10],
            a[9:0]});
         u_sbr_ctrl_model.issue(a[15] ? CMD_WRITE : CMD_READ, a);
      end
      // Nine refreshes: eight fill credit to the pull-in limit, the ninth saturates there
      for (int i = 0; i < 9; i++)
      begin
         row_e++;
         cred_e = (cred_e < 5'h10) ? cred_e + 5'h01 : cred_e;
         expq.push_back({14'h0, row_e, cred_e});
         u_sbr_ctrl_model.issue(CMD_REFRESH, 16'($random(seed)));
         u_sbr_ctrl_model.issue(CMD_READ, 16'($random(seed)));
      end
      u_sbr_ctrl_model.issue(CMD_NOP, 16'h0000);
      #1;
      `CHK(expq.size(), 0)
      `CHK(ovd, 1'b0)
      // Seventeen intervals with no refresh: sixteen drain the credit,
      // the seventeenth finds none left and flags overdue
      repeat (17 * 4000) @(posedge sys_clk);
      #1;
      `CHK(cred, 5'h00)
      `CHK(ovd, 1'b1)
      // Paying back the missed refresh clears the flag
      row_e++;
      expq.push_back({14'h0, row_e, 5'h01});
      u_sbr_ctrl_model.issue(CMD_REFRESH, 16'($random(seed)));
      u_sbr_ctrl_model.issue(CMD_NOP, 16'h0000);
      #1;
      `CHK(ovd, 1'b0)
      `CHK(expq.size(), 0)
      // Mid-run reset brings every counter back to its start value
      rst_b = 1'b0;
      repeat (12) @(posedge sys_clk);
      #1 rst_b = 1'b1;
      `CHK({row, cred, ovd, idle, beats},
         {13'h0000, 5'h08, 1'b0, 1'b1, 4'h8})
      tally_and_finish();
   end
endmodule
